// ===== hdl/icab_pkg.sv
// Purpose: Shared constants and carrier types for the indirect CSR bridge
// Assumes: APB slave with 32-bit data, byte addressing
// Notes: Fabric side is a simple request/acknowledge port
package icab_pkg;
    localparam logic [11:0] ICAB_DATA_OFFSET = 12'h1AC;
    localparam logic [11:0] ICAB_CMD_OFFSET = 12'h1B0;
    localparam int ICAB_PEND_BIT = 31;
    localparam int ICAB_RNW_BIT = 30;
    localparam int ICAB_UP_BIT = 29;
    localparam int ICAB_DOWN_BIT = 28;
    localparam int ICAB_MASK_LSB = 16;
    localparam int ICAB_MASK_W = 4;
    localparam int ICAB_IDX_W = 16;
    localparam logic [31:0] ICAB_DATA_RESET = 32'h00000000;
    localparam logic [3:0] ICAB_MASK_RESET = 4'h0;
    localparam logic [15:0] ICAB_IDX_RESET = 16'h0000;

    // Request toward the fabric register block
    typedef struct packed {
        logic valid;
        logic read_not_write;
        logic [3:0] lane_write_mask;
        logic [15:0] target_register_index;
        logic [31:0] wdata;
    } icab_req_t;

    // Answer from the fabric register block
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } icab_rsp_t;

    typedef enum logic [1:0] {
        ICAB_IDLE = 2'b01,
        ICAB_WAIT = 2'b10
    } icab_state_t;
endpackage

// ===== hdl/icab_bridge.sv
// Purpose: Indirect access path from APB into fabric control and status registers
// Assumes: Fabric holds ack high for one cycle per request; one request in flight
// Notes: Zero wait states on APB; fabric request held from flops
// Function
// - Data register carries transferred fabric value
// - Data read returns fabric data if read
// - Writing pending bit launches one access
// - Pending holds during access, then clears
// - Pending clear means read data valid
// - Bit 30 selects read (1) or write
// - Step-up data write starts, then increments
// - Step-up data read increments, starts read
// - Step-down data write starts, then decrements
// - Step-down data read decrements, starts read
// - Step-up wins over step-down
// - Lane mask gates written fabric bytes
// - Bits 15:0 hold target index, reset zero
`timescale 1ns/1ns
module icab_bridge
    import icab_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output icab_req_t fab_req,
    input wire icab_rsp_t fab_rsp
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] data_q;
    logic [31:0] data_d;
    logic pend_q;
    logic pend_d;
    logic rnw_q;
    logic rnw_d;
    logic up_q;
    logic up_d;
    logic down_q;
    logic down_d;
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    logic [15:0] idx_q;
    logic [15:0] idx_d;
    logic step_after_q;
    logic step_after_d;
    icab_state_t state_q;
    icab_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire access = psel && penable && clk_en;
    wire hit_data = (paddr == ICAB_DATA_OFFSET);
    wire hit_cmd = (paddr == ICAB_CMD_OFFSET);
    wire wr_data = access && pwrite && hit_data;
    wire wr_cmd = access && pwrite && hit_cmd;
    wire rd_data = access && !pwrite && hit_data;
    wire stepping = up_q || down_q;
    wire fab_done = (state_q == ICAB_WAIT) && fab_rsp.ack;
    wire [31:0] cmd_view = {pend_q, rnw_q, up_q, down_q, 8'h00, mask_q, idx_q};
    wire [15:0] idx_up = idx_q + 16'h0001;
    wire [15:0] idx_down = idx_q - 16'h0001;
    wire [15:0] idx_step = up_q ? idx_up : idx_down;
    wire cmd_start = wr_cmd && pwdata[ICAB_PEND_BIT] && pstrb[3];
    wire auto_start = (wr_data || rd_data) && stepping;
    wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Read data: the data register shows the last host write or fabric read; a fabric read in the same cycle as a host write wins
    assign prdata = hit_data ? data_q : (hit_cmd ? cmd_view : 32'h00000000);

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        data_d = data_q;
        pend_d = pend_q;
        rnw_d = rnw_q;
        up_d = up_q;
        down_d = down_q;
        mask_d = mask_q;
        idx_d = idx_q;
        step_after_d = step_after_q;
        state_d = state_q;
        if (wr_data)
        begin
            data_d = (data_q & ~strb_mask) | (pwdata & strb_mask);
        end
        if (wr_cmd)
        begin
            if (pstrb[3])
            begin
                rnw_d = pwdata[ICAB_RNW_BIT];
                up_d = pwdata[ICAB_UP_BIT];
                down_d = pwdata[ICAB_DOWN_BIT];
            end
            if (pstrb[2])
            begin
                mask_d = pwdata[ICAB_MASK_LSB +: ICAB_MASK_W];
            end
            if (pstrb[1])
            begin
                idx_d[15:8] = pwdata[15:8];
            end
            if (pstrb[0])
            begin
                idx_d[7:0] = pwdata[7:0];
            end
        end
        unique case (state_q)
            ICAB_IDLE:
            begin
                if (rd_data && stepping && rnw_q)
                begin
                    idx_d = idx_step;
                end
                if (cmd_start || auto_start)
                begin
                    pend_d = 1'b1;
                    state_d = ICAB_WAIT;
                    step_after_d = auto_start && !rnw_q;
                end
            end
            ICAB_WAIT:
            begin
                if (fab_done)
                begin
                    pend_d = 1'b0;
                    state_d = ICAB_IDLE;
                    step_after_d = 1'b0;
                    if (rnw_q)
                    begin
                        data_d = fab_rsp.rdata;
                    end
                    if (step_after_q)
                    begin
                        idx_d = idx_step;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_q <= ICAB_DATA_RESET;
            pend_q <= 1'b0;
            rnw_q <= 1'b0;
            up_q <= 1'b0;
            down_q <= 1'b0;
            mask_q <= ICAB_MASK_RESET;
            idx_q <= ICAB_IDX_RESET;
            step_after_q <= 1'b0;
            state_q <= ICAB_IDLE;
        end
        else if (clk_en)
        begin
            data_q <= data_d;
            pend_q <= pend_d;
            rnw_q <= rnw_d;
            up_q <= up_d;
            down_q <= down_d;
            mask_q <= mask_d;
            idx_q <= idx_d;
            step_after_q <= step_after_d;
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fabric request, held from flops while pending
    always_comb
    begin
        fab_req.valid = (state_q == ICAB_WAIT);
        fab_req.read_not_write = rnw_q;
        fab_req.lane_write_mask = mask_q;
        fab_req.target_register_index = idx_q;
        fab_req.wdata = data_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence launch_s;
        clk_en && (state_q == ICAB_IDLE) && (cmd_start || auto_start);
    endsequence

    sequence done_s;
        clk_en && fab_done;
    endsequence

    pend_follows_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
        launch_s |=> pend_q && fab_req.valid)
        else $error("Launch did not raise pending");

    pend_holds_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        pend_q && !fab_done |=> pend_q)
        else $error("Pending dropped before ack");

    pend_clears_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s |=> !pend_q)
        else $error("Pending not cleared after ack");

    read_data_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s and rnw_q |=> data_q == $past(fab_rsp.rdata))
        else $error("Read data not latched");

    req_matches_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        fab_req.valid == pend_q)
        else $error("Request valid differs from pending");

    data_read_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_data |-> prdata == data_q)
        else $error("Data read path wrong");

    step_write_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s and step_after_q and up_q |=> idx_q == $past(idx_q) + 16'h0001)
        else $error("Index not stepped up after write");

    step_read_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ICAB_IDLE && rd_data && !up_q && down_q && rnw_q
        |=> idx_q == $past(idx_q) - 16'h0001 && pend_q)
        else $error("Index not stepped down on read");

    cmd_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_cmd |-> prdata[ICAB_RNW_BIT] == rnw_q && prdata[15:0] == idx_q)
        else $error("Command readback wrong");

    req_after_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s
        |=> !fab_req.valid)
        else $error("Request still valid after ack");

    req_index_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && fab_req.valid && !fab_done && !wr_cmd
        |=> $stable(fab_req.target_register_index))
        else $error("Request index moved while pending");

    req_wdata_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && fab_req.valid && !fab_done && !wr_data
        |=> $stable(fab_req.wdata))
        else $error("Request data moved while pending");

    step_up_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ICAB_IDLE && rd_data && up_q && rnw_q
        |=> idx_q == $past(idx_q) + 16'h0001 && pend_q)
        else $error("Index not stepped up on read");

    step_both_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ICAB_IDLE && rd_data && up_q && down_q && rnw_q
        |=> idx_q == $past(idx_q) + 16'h0001)
        else $error("Step-up did not win on read");

    step_down_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s and step_after_q and !up_q
        |=> idx_q == $past(idx_q) - 16'h0001)
        else $error("Index not stepped down after write");

    step_both_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s and step_after_q and up_q and down_q
        |=> idx_q == $past(idx_q) + 16'h0001)
        else $error("Step-up did not win on write");

    plain_read_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ICAB_IDLE && rd_data && !stepping
        |=> !pend_q)
        else $error("Plain data read launched an access");

    read_launch_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ICAB_IDLE && rd_data && stepping && rnw_q
        |=> fab_req.valid && fab_req.read_not_write)
        else $error("Stepped read not launched as read");

    data_write_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && pstrb == 4'hF && !(fab_done && rnw_q)
        |=> data_q == $past(pwdata))
        else $error("Host write not held in data register");

    write_keeps_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_s and !rnw_q and !wr_data
        |=> data_q == $past(data_q))
        else $error("Fabric write changed data register");

    unmapped_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !hit_data && !hit_cmd
        |-> prdata == 32'h00000000)
        else $error("Unmapped read not zero");

    reserved_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_cmd
        |-> prdata[27:20] == 8'h00)
        else $error("Reserved command bits not zero");

    pend_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_cmd
        |-> prdata[ICAB_PEND_BIT] == pend_q)
        else $error("Pending readback wrong");

    freeze_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en
        |=> $stable(pend_q) && $stable(idx_q) && $stable(data_q))
        else $error("State moved while clock enable low");

    pend_only_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !pend_q && !cmd_start && !auto_start
        |=> !pend_q)
        else $error("Pending set without launch");

endmodule

// ===== tb/icab_fabric_model.sv
// Purpose: Behavioural fabric register block answering bridge requests
// Assumes: One request at a time, ack after a programmable delay
// Notes: Unwritten registers read a pattern built from the index
`timescale 1ns/1ns
module icab_fabric_model
    import icab_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] delay,
    input wire icab_req_t fab_req,
    output icab_rsp_t fab_rsp
);
    logic [31:0] mem [256];
    logic [3:0] cnt_q;
    logic [7:0] idx;
    assign idx = fab_req.target_register_index[7:0];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = {24'hFAB000, 8'(i)};
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fab_rsp <= '0;
            cnt_q <= 4'h0;
        end
        else if (fab_req.valid && !fab_rsp.ack && cnt_q >= delay)
        begin
            fab_rsp.ack <= 1'b1;
            fab_rsp.rdata <= mem[idx];
            for (int b = 0; b < 4; b++)
                if (!fab_req.read_not_write && fab_req.lane_write_mask[b])
                    mem[idx][8*b+:8] <= fab_req.wdata[8*b+:8];
            cnt_q <= 4'h0;
        end
        else
        begin
            fab_rsp.ack <= 1'b0;
            fab_rsp.rdata <= ~fab_rsp.rdata;
            cnt_q <= fab_req.valid ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the indirect CSR bridge
// Assumes: Fabric model acks after a set delay
// Notes: Registers reached through APB tasks
`timescale 1ns/1ns
module testbench import icab_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic [3:0] pstrb = 4'hF, dly = 4'h0;
    logic en = 1'b1;
    logic [3:0] st [3] = '{4'h2, 4'h1, 4'h3};
    logic pready, pslverr;
    icab_req_t fab_req;
    icab_rsp_t fab_rsp;
    int bad_count = 0, comparisons = 0;
    always #4 pclk = ~pclk;
    icab_bridge DUT (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fab_req(fab_req),
        .fab_rsp(fab_rsp));
    icab_fabric_model fab (.pclk(pclk), .presetn(presetn), .delay(dly), .fab_req(fab_req),
        .fab_rsp(fab_rsp));
    task automatic give_verdict();
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ICAB_CMD_OFFSET, 32'h0);
            n++;
        end
        while (q[ICAB_PEND_BIT] !== 1'b0 && n < 40);
        if (q[ICAB_PEND_BIT] !== 1'b0)
            bad_count++;
    endtask
    function automatic logic [31:0] cw(input logic [3:0] f, input logic [3:0] m,
        input logic [15:0] i);
        return {f, 8'h00, m, i};
    endfunction
    initial
    begin
        #100000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, ICAB_CMD_OFFSET, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h1A8, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, ICAB_DATA_OFFSET, 32'h11223344);
        apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
        chk(q, 32'h11223344);
        en <= 1'b0;
        apb(1'b1, ICAB_DATA_OFFSET, 32'h55555555);
        en <= 1'b1;
        apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
        chk(q, 32'h11223344);
        dly <= 4'h8;
        apb(1'b1, ICAB_CMD_OFFSET, cw(4'h8, 4'hF, 16'h0005));
        apb(1'b0, ICAB_CMD_OFFSET, 32'h0);
        chk(q, cw(4'h8, 4'hF, 16'h0005));
        idle();
        chk(q, cw(4'h0, 4'hF, 16'h0005));
        apb(1'b1, ICAB_DATA_OFFSET, 32'hAABBCCDD);
        apb(1'b1, ICAB_CMD_OFFSET, cw(4'h8, 4'h5, 16'h0005));
        idle();
        apb(1'b1, ICAB_CMD_OFFSET, cw(4'hC, 4'hF, 16'h0005));
        idle();
        apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
        chk(q, 32'h11BB33DD);
        for (int k = 0; k < 3; k++)
        begin
            dly <= k[0] ? 4'h0 : 4'h3;
            apb(1'b1, ICAB_CMD_OFFSET, cw(st[k], 4'hF, k == 1 ? 16'h0009 : 16'h0008));
            apb(1'b1, ICAB_DATA_OFFSET, 32'hC0DE0000 + k);
            idle();
            chk(q, cw(st[k], 4'hF, k == 1 ? 16'h0008 : 16'h0009));
        end
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, ICAB_CMD_OFFSET, cw(k ? 4'hD : 4'hE, 4'hF, 16'(8 + k)));
            idle();
            apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
            chk(q, 32'hC0DE0002 - k);
            idle();
            chk(q, cw(k ? 4'h5 : 4'h6, 4'hF, 16'(9 - k)));
            apb(1'b1, ICAB_CMD_OFFSET, cw(4'h4, 4'hF, 16'(9 - k)));
            apb(1'b0, ICAB_DATA_OFFSET, 32'h0);
            chk(q, 32'hC0DE0001 + k);
            apb(1'b0, ICAB_CMD_OFFSET, 32'h0);
            chk(q, cw(4'h4, 4'hF, 16'(9 - k)));
        end
        give_verdict();
    end
endmodule
